//--- hw/rtc_cfg.svh
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
// Timing
`define CLK_HZ 100_000_000
`define TICK_HZ 32'd65536
`define HALF_SCLK 8'd4
`define DIV_4K 4'hF
`define DIV_64 10'h3FF
// Banks
`define B_TIME 3'h1
`define B_STAMP 3'h2
`define B_PWR 3'h3
// Bank 1 offsets
`define A_SEC 4'h0
`define A_MIN 4'h1
`define A_HOUR 4'h2
`define A_WEEK 4'h3
`define A_DAY 4'h4
`define A_MON 4'h5
`define A_YEAR 4'h6
`define A_AMIN 4'h7
`define A_AHOUR 4'h8
`define A_AWEEK 4'h9
`define A_TC0 4'hA
`define A_TC1 4'hB
`define A_TC2 4'hC
`define A_EXT 4'hD
`define A_FLAG 4'hE
`define A_CTRL 4'hF
// Bank 2 and 3 offsets
`define A_TSLAST 4'h8
`define A_ASEC 4'hC
`define A_TCTL 4'hD
`define A_TSCTL 4'h4
// Fields
`define F_AE 7
`define F_TF 4
`define F_AF 3
`define F_VLF 1
`define F_TIE 4
`define F_AIE 3
`define F_TE 4
`define F_WADA 3
`define F_FSEL 7:6
`define F_TSEL 1:0
`define F_TBKON 3
`define F_TBKE 2
`define F_TSRAM 0
// Encodings
`define FS_1K 2'h1
`define FS_1HZ 2'h2
`define TS_4K 2'h0
`define TS_64 2'h1
`define TS_SEC 2'h2
// Reset values
`define RST_DATE 8'h01
`define RST_WEEK 8'h01
`define RST_FLAG 8'h02
`endif

//--- hw/rtc_pkg.sv
package rtc_pkg;
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_SHIFT = 3'b010,
        H_END = 3'b100
    } host_st_t;

    typedef struct packed {
        logic [31:0] acc;
        logic [15:0] sub;
        logic clk_o;
        logic [7:0] sec, min, hour, week, day, mon, year;
        logic [7:0] amin, ahour, aweek, asec;
        logic [23:0] reload, tcnt;
        logic [7:0] ext, flag, ctrl, tctl, tsctl;
        logic [8:0][7:0] ts;
        logic [63:0][7:0] ram;
        logic chk;
        logic [7:0] rdata;
        logic ws1, ws2, wseen, rs1, rs2, rseen;
        logic vl1, vl2, bk1, bk2, tr1, tr2, tr3;
    } core_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [6:0] sh;
        logic first, rd, ok;
        logic [2:0] bank;
        logic [3:0] addr;
        logic [7:0] tx;
    } link_t;

    typedef struct packed {
        logic wtog, rtog, as1, as2;
        logic [2:0] wbank, rbank;
        logic [3:0] waddr, raddr;
        logic [7:0] wdata;
    } hs_t;

    typedef struct packed {
        host_st_t st;
        logic [7:0] div;
        logic sclk, ce, sdi;
        logic [23:0] tx;
        logic [4:0] nb, bi;
        logic [7:0] rx, rdata;
        logic do1, do2, done;
    } host_t;
endpackage : rtc_pkg

//--- hw/rtc_link_if.sv
`timescale 1ns/1ps
interface rtc_link_if;
    logic ce;
    logic sclk;
    logic sdi;
    logic sdo;
    modport dev (input ce, input sclk, input sdi, output sdo);
    modport host (output ce, output sclk, output sdi, input sdo);
endinterface : rtc_link_if

//--- hw/rtc_dev.sv
// Summary of operation
// - Host sets and reads calendar counters
// - Year divisible by four is leap
// - Seconds accept written value sixty
// - Wake-up timer repeats at programmable period
// - Timer event sets flag, drives interrupt
// - Timer counts main and backup supply time
// - Alarm fires when time matches settings
// - Alarm event sets flag, drives interrupt
// - Supply drop returns device to reset
// - Data-loss flag set on low supply
// - Clock out 32768, 1024 or 1 Hz
// - Time stamp captures fraction through year
// - Sixty-four bytes of free user memory
// - Stamp storage is memory when unused
// - Transfer opens with 4-bit mode code
// - Read codes 9h-Fh pick banks 1-7
// - Write codes 1h-7h pick banks 1-7
// - Host initialises unused function registers
// - Byte committed only after eight bits
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_dev import rtc_pkg::*; #(
    parameter int unsigned CLK_HZ = `CLK_HZ
) (
    // Core clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link
    rtc_link_if.dev lnk,
    // Supply and trigger inputs
    input wire logic vdd_low,
    input wire logic on_backup,
    input wire logic ts_trig,
    // Outputs
    output logic int_n,
    output logic clock_out_pin
);
    core_t r, n;
    link_t lk, ln;
    hs_t hs, hn;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0}
                                   : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic [8:0] roll(input logic [7:0] v,
        input logic [7:0] top, input logic [7:0] lo);
        roll = (v >= top) ? {1'b1, lo} : {1'b0, bcd_inc(v)};
    endfunction : roll

    function automatic logic leap(input logic [7:0] y);
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    endfunction : leap

    function automatic logic [7:0] dim(input logic [7:0] m,
        input logic [7:0] y);
        case (m)
            8'h02: dim = leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
            default: dim = 8'h31;
        endcase
    endfunction : dim

    function automatic core_t core_init();
        core_init = '0;
        core_init.week = `RST_WEEK;
        core_init.day = `RST_DATE;
        core_init.mon = `RST_DATE;
        core_init.flag = `RST_FLAG;
    endfunction : core_init

    function automatic logic [7:0] peek(input core_t c, input logic [2:0] b,
        input logic [3:0] a);
        peek = 8'h00;
        case (b)
            `B_TIME: begin
                case (a)
                    `A_SEC: peek = c.sec;
                    `A_MIN: peek = c.min;
                    `A_HOUR: peek = c.hour;
                    `A_WEEK: peek = c.week;
                    `A_DAY: peek = c.day;
                    `A_MON: peek = c.mon;
                    `A_YEAR: peek = c.year;
                    `A_AMIN: peek = c.amin;
                    `A_AHOUR: peek = c.ahour;
                    `A_AWEEK: peek = c.aweek;
                    `A_TC0: peek = c.tcnt[7:0];
                    `A_TC1: peek = c.tcnt[15:8];
                    `A_TC2: peek = c.tcnt[23:16];
                    `A_EXT: peek = c.ext;
                    `A_FLAG: peek = c.flag;
                    default: peek = c.ctrl;
                endcase
            end
            `B_STAMP: begin
                if (a <= `A_TSLAST) peek = c.ts[a];
                else if (a == `A_ASEC) peek = c.asec;
                else if (a == `A_TCTL) peek = c.tctl;
            end
            `B_PWR: if (a == `A_TSCTL) peek = c.tsctl;
            default: if (b[2]) peek = c.ram[{b[1:0], a}];
        endcase
    endfunction : peek

    // Core domain
    always_comb begin
        logic tick, sec_t, c1, c2, c3, c4, c5, src, run, tev, aev;
        logic [7:0] wd;
        core_t t;
        tick = 1'b0;
        src = 1'b0;
        tev = 1'b0;
        aev = 1'b0;
        wd = hs.wdata;
        t = core_init();
        n = r;
        if (r.acc + `TICK_HZ >= CLK_HZ) begin
            n.acc = r.acc + `TICK_HZ - CLK_HZ;
            tick = 1'b1;
        end else begin
            n.acc = r.acc + `TICK_HZ;
        end
        if (tick) n.sub = r.sub + 16'h0001;
        sec_t = tick && (r.sub == 16'hFFFF);
        case (r.ext[`F_FSEL])
            `FS_1K: n.clk_o = r.sub[5];
            `FS_1HZ: n.clk_o = r.sub[15];
            default: n.clk_o = r.sub[0];
        endcase
        // Calendar chain, BCD except the one-hot weekday rotation
        {c1, n.sec} = sec_t ? roll(r.sec, 8'h59, 8'h00) : {1'b0, r.sec};
        {c2, n.min} = c1 ? roll(r.min, 8'h59, 8'h00) : {1'b0, r.min};
        {c3, n.hour} = c2 ? roll(r.hour, 8'h23, 8'h00) : {1'b0, r.hour};
        {c4, n.day} = c3 ? roll(r.day, dim(r.mon, r.year), `RST_DATE)
                         : {1'b0, r.day};
        {c5, n.mon} = c4 ? roll(r.mon, 8'h12, `RST_DATE) : {1'b0, r.mon};
        if (c5) n.year = (r.year >= 8'h99) ? 8'h00 : bcd_inc(r.year);
        if (c3) n.week = {1'b0, r.week[5:0], r.week[6]};
        // Wake-up timer; 24-bit count of minutes reaches about 32 years
        case (r.ext[`F_TSEL])
            `TS_4K: src = tick && (r.sub[3:0] == `DIV_4K);
            `TS_64: src = tick && (r.sub[9:0] == `DIV_64);
            `TS_SEC: src = sec_t;
            default: src = c1;
        endcase
        run = r.ext[`F_TE] && (r.bk2 ? (r.tctl[`F_TBKE] | r.tctl[`F_TBKON])
                                     : !r.tctl[`F_TBKON]);
        if (run && src) begin
            if (r.tcnt <= 24'h000001) begin
                n.tcnt = r.reload;
                tev = 1'b1;
            end else begin
                n.tcnt = r.tcnt - 24'h000001;
            end
        end
        // Alarm compared one cycle after the second rolls
        n.chk = sec_t;
        if (r.chk) begin
            aev = (r.asec[`F_AE] || r.asec[6:0] == r.sec[6:0])
                && (r.amin[`F_AE] || r.amin[6:0] == r.min[6:0])
                && (r.ahour[`F_AE] || r.ahour[5:0] == r.hour[5:0])
                && (r.aweek[`F_AE] || (r.ext[`F_WADA]
                    ? r.aweek[5:0] == r.day[5:0]
                    : |(r.aweek[6:0] & r.week[6:0])));
        end
        // Synchronisers
        n.ws1 = hs.wtog;
        n.ws2 = r.ws1;
        n.rs1 = hs.rtog;
        n.rs2 = r.rs1;
        n.vl1 = vdd_low;
        n.vl2 = r.vl1;
        n.bk1 = on_backup;
        n.bk2 = r.bk1;
        n.tr1 = ts_trig;
        n.tr2 = r.tr1;
        n.tr3 = r.tr2;
        if (r.tr2 && !r.tr3 && !r.tsctl[`F_TSRAM]) begin
            n.ts = {r.year, r.mon, r.day, r.week, r.hour, r.min, r.sec,
                    r.sub[15:8], 6'h00, r.sub[7:6]};
        end
        // Host write lands after the count, so it wins that field
        if (r.ws2 != r.wseen) begin
            n.wseen = r.ws2;
            case (hs.wbank)
                `B_TIME: begin
                    case (hs.waddr)
                        `A_SEC: n.sec = wd;
                        `A_MIN: n.min = wd;
                        `A_HOUR: n.hour = wd;
                        `A_WEEK: n.week = wd;
                        `A_DAY: n.day = wd;
                        `A_MON: n.mon = wd;
                        `A_YEAR: n.year = wd;
                        `A_AMIN: n.amin = wd;
                        `A_AHOUR: n.ahour = wd;
                        `A_AWEEK: n.aweek = wd;
                        `A_TC0: n.reload[7:0] = wd;
                        `A_TC1: n.reload[15:8] = wd;
                        `A_TC2: n.reload[23:16] = wd;
                        `A_EXT: n.ext = wd;
                        `A_FLAG: n.flag = r.flag & wd;
                        default: n.ctrl = wd;
                    endcase
                    if (hs.waddr >= `A_TC0 && hs.waddr <= `A_TC2) begin
                        n.tcnt = n.reload;
                    end
                end
                `B_STAMP: begin
                    if (hs.waddr <= `A_TSLAST && r.tsctl[`F_TSRAM]) begin
                        n.ts[hs.waddr] = wd;
                    end else if (hs.waddr == `A_ASEC) begin
                        n.asec = wd;
                    end else if (hs.waddr == `A_TCTL) begin
                        n.tctl = wd;
                    end
                end
                `B_PWR: if (hs.waddr == `A_TSCTL) n.tsctl = wd;
                default: begin
                    if (hs.wbank[2]) begin
                        n.ram[{hs.wbank[1:0], hs.waddr}] = wd;
                    end
                end
            endcase
        end
        // Set after clear so an event never gets lost
        if (tev) n.flag[`F_TF] = 1'b1;
        if (aev) n.flag[`F_AF] = 1'b1;
        if (r.rs2 != r.rseen) begin
            n.rseen = r.rs2;
            n.rdata = peek(r, hs.rbank, hs.raddr);
        end
        if (rst) begin
            n = core_init();
        end else if (r.vl2) begin
            // Handshake state survives so the link stays in step
            t.ws1 = n.ws1;
            t.ws2 = n.ws2;
            t.wseen = n.wseen;
            t.rs1 = n.rs1;
            t.rs2 = n.rs2;
            t.rseen = n.rseen;
            t.rdata = n.rdata;
            t.vl1 = n.vl1;
            t.vl2 = n.vl2;
            n = t;
        end
    end

    always_ff @(posedge clk) begin
        r <= n;
    end

    assign int_n = !((r.flag[`F_TF] & r.ctrl[`F_TIE])
                   | (r.flag[`F_AF] & r.ctrl[`F_AIE]));
    assign clock_out_pin = r.clk_o;

    // Link domain
    always_comb begin
        logic [7:0] full;
        full = {lk.sh, lnk.sdi};
        ln = lk;
        hn = hs;
        ln.cnt = lk.cnt + 3'h1;
        ln.sh = full[6:0];
        ln.tx = {lk.tx[6:0], 1'b0};
        hn.as1 = r.rseen;
        hn.as2 = hs.as1;
        if (lk.cnt == 3'h7) begin
            if (!lk.first) begin
                ln.first = 1'b1;
                ln.rd = full[7];
                ln.bank = full[6:4];
                ln.ok = (full[6:4] != 3'h0);
                ln.addr = full[3:0];
                if (full[7]) begin
                    hn.rbank = full[6:4];
                    hn.raddr = full[3:0];
                    hn.rtog = !hs.rtog;
                end
            end else if (!lk.rd) begin
                if (lk.ok) begin
                    hn.wbank = lk.bank;
                    hn.waddr = lk.addr;
                    hn.wdata = full;
                    hn.wtog = !hs.wtog;
                end
                ln.addr = lk.addr + 4'h1;
            end else begin
                ln.tx = (hs.as2 == hs.rtog) ? r.rdata : 8'h00;
                hn.raddr = hs.raddr + 4'h1;
                hn.rtog = !hs.rtog;
            end
        end
    end

    // Frame state dies with chip enable, so a short byte never commits
    always_ff @(posedge lnk.sclk or negedge lnk.ce) begin
        if (!lnk.ce) lk <= '0;
        else lk <= ln;
    end

    always_ff @(posedge lnk.sclk or posedge rst) begin
        if (rst) hs <= '0;
        else hs <= hn;
    end

    assign lnk.sdo = lk.tx[7];
endmodule : rtc_dev

//--- hw/rtc_host.sv
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_host import rtc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link
    rtc_link_if.host lnk,
    // Command port
    input wire logic req,
    input wire logic wr,
    input wire logic [2:0] bank,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    // Answer
    output logic ready,
    output logic done,
    output logic [7:0] rdata
);
    host_t r, n;

    always_comb begin
        n = r;
        n.done = 1'b0;
        n.do1 = lnk.sdo;
        n.do2 = r.do1;
        case (r.st)
            H_IDLE: begin
                // Bank zero has no mode code, so it is ignored
                if (req && bank != 3'h0) begin
                    n.st = H_SHIFT;
                    n.ce = 1'b1;
                    n.div = 8'h00;
                    n.bi = 5'h00;
                    n.tx = {!wr, bank, addr, wr ? wdata : 8'h00,
                            8'h00};
                    n.sdi = !wr;
                    n.nb = wr ? 5'h10 : 5'h18;
                end
            end
            H_SHIFT: begin
                n.div = r.div + 8'h01;
                if (r.div == `HALF_SCLK - 8'h01) begin
                    n.div = 8'h00;
                    if (!r.sclk) begin
                        n.sclk = 1'b1;
                        // Reads carry a turnaround byte before data
                        if (r.bi >= 5'h10) n.rx = {r.rx[6:0], r.do2};
                    end else begin
                        n.sclk = 1'b0;
                        n.bi = r.bi + 5'h01;
                        n.tx = {r.tx[22:0], 1'b0};
                        n.sdi = r.tx[22];
                        if (r.bi + 5'h01 == r.nb) n.st = H_END;
                    end
                end
            end
            H_END: begin
                n.div = r.div + 8'h01;
                if (r.div == `HALF_SCLK - 8'h01) begin
                    n.div = 8'h00;
                    if (r.ce) begin
                        n.ce = 1'b0;
                    end else begin
                        n.st = H_IDLE;
                        n.done = 1'b1;
                        n.rdata = r.rx;
                    end
                end
            end
            default: n.st = H_IDLE;
        endcase
        if (rst) begin
            n = '0;
            n.st = H_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        r <= n;
    end

    assign ready = (r.st == H_IDLE);
    assign done = r.done;
    assign rdata = r.rdata;
    assign lnk.ce = r.ce;
    assign lnk.sclk = r.sclk;
    assign lnk.sdi = r.sdi;
endmodule : rtc_host

//--- tb/rtc_link_properties.sv
`timescale 1ns/1ps
module rtc_link_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link wires
    input wire logic ce,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo
);
    logic [4:0] cnt_r;
    logic [3:0] mode_r;
    logic sclk_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Rises per frame, cleared between frames
    always_ff @(posedge clk) begin
        sclk_r <= sclk;
        if (rst || !ce) begin
            cnt_r <= 5'h00;
            mode_r <= 4'h0;
        end else if (sclk && !sclk_r) begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r < 5'h04) begin
                mode_r <= {mode_r[2:0], sdi};
            end
        end
    end
    property p_sclk_idle; !ce |-> !sclk; endproperty
    property p_sdo_idle; (!ce)[*4] |-> !sdo; endproperty
    property p_sdi_hold; sclk && $past(sclk) |-> $stable(sdi); endproperty
    property p_high_time; $rose(sclk) |-> sclk[*4] ##1 !sclk; endproperty
    property p_first_rise; $rose(ce) |-> !sclk ##[1:8] $rose(sclk); endproperty
    property p_frame_len;
        $fell(ce) |-> cnt_r == (mode_r[3] ? 5'h18 : 5'h10);
    endproperty
    property p_mode_bank;
        cnt_r == 5'h04 && $past(cnt_r) == 5'h03 |-> mode_r[2:0] != 3'h0;
    endproperty
    // Host must let go soon after the last bit
    property p_release;
        $fell(sclk) && cnt_r == (mode_r[3] ? 5'h18 : 5'h10) |-> ##[1:8] !ce;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("sclk");
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo");
    a_sdi_hold: assert property (p_sdi_hold) else $error("sdi");
    a_high_time: assert property (p_high_time) else $error("high");
    a_first_rise: assert property (p_first_rise) else $error("rise");
    a_frame_len: assert property (p_frame_len) else $error("len");
    a_mode_bank: assert property (p_mode_bank) else $error("mode");
    a_release: assert property (p_release) else $error("ce");
    c_write: cover property ($fell(ce) && !mode_r[3]);
    c_read: cover property ($fell(ce) && mode_r[3]);
    c_sdo: cover property (ce && sdo);
endmodule : rtc_link_properties

//--- tb/test_rtc_function_set_bank_select.sv
`timescale 1ns/1ps
module test_rtc_function_set_bank_select;
    localparam int HZ = 65536;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic [2:0] bank = 3'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic vdd_low = 1'b0;
    logic on_backup = 1'b0;
    logic ts_trig = 1'b0;
    logic ready, done, int_n, clk_o;
    logic [7:0] rdata;
    logic [31:0] seed = 32'h7BF16C68;
    int model [1:7][0:15];
    int n_mismatch = 0;
    int checks = 0;
    rtc_link_if bus();
    rtc_link_if bus_b();
    always #5 clk = ~clk;
    rtc_dev #(.CLK_HZ(HZ)) rtc_dev_inst (.clk(clk), .rst(rst), .lnk(bus),
        .vdd_low(vdd_low), .on_backup(on_backup), .ts_trig(ts_trig),
        .int_n(int_n), .clock_out_pin(clk_o));
    // Second device, driven raw to cut a byte short
    rtc_dev #(.CLK_HZ(HZ)) rtc_dev_inst_b (.clk(clk), .rst(rst),
        .lnk(bus_b), .vdd_low(vdd_low), .on_backup(on_backup),
        .ts_trig(ts_trig), .int_n(), .clock_out_pin());
    rtc_host rtc_host_inst (.clk(clk), .rst(rst), .lnk(bus), .req(req),
        .wr(wr), .bank(bank), .addr(addr), .wdata(wdata), .ready(ready),
        .done(done), .rdata(rdata));
    rtc_link_properties rtc_link_properties_inst (.clk(clk), .rst(rst),
        .ce(bus.ce), .sclk(bus.sclk), .sdi(bus.sdi), .sdo(bus.sdo));

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic print_verdict();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string msg);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s %h/%h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic model_reset();
        foreach (model[b, a]) begin
            model[b][a] = 0;
        end
        model[1][3] = 1;
        model[1][4] = 1;
        model[1][5] = 1;
        model[1][14] = 2;
    endtask : model_reset

    task automatic xfer(input logic w, input logic [2:0] b,
                        input logic [3:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        int n;
        @(negedge clk);
        req = 1'b1;
        wr = w;
        bank = b;
        addr = a;
        wdata = d;
        n = 0;
        while (ready !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req = 1'b0;
        while (done !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        check({7'h00, done}, 8'h01, "done");
        q = rdata;
    endtask : xfer

    task automatic wr_reg(input logic [2:0] b, input logic [3:0] a,
                          input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, b, a, d, q);
        model[b][a] = int'(d);
    endtask : wr_reg

    task automatic rd_chk(input logic [2:0] b, input logic [3:0] a,
                          input string msg);
        logic [7:0] q;
        xfer(1'b0, b, a, 8'h00, q);
        check(q, model[b][a][7:0], msg);
    endtask : rd_chk

    // Own link clock, 12 ns, still between frames
    task automatic raw(input logic [23:0] bits, input int n,
                       output logic [23:0] got);
        got = 24'h000000;
        bus_b.sdi = bits[23];
        #3;
        bus_b.ce = 1'b1;
        for (int i = 0; i < n; i++) begin
            bus_b.sdi = bits[23 - i];
            #6;
            got = {got[22:0], bus_b.sdo};
            bus_b.sclk = 1'b1;
            #6;
            bus_b.sclk = 1'b0;
        end
        #6;
        bus_b.ce = 1'b0;
        bus_b.sdi = ~bus_b.sdi;
        #60;
    endtask : raw

    task automatic measure(output logic [7:0] p);
        int n, t0;
        n = 0;
        t0 = 0;
        for (int e = 0; e < 4; e++) begin
            while (clk_o !== e[0] && n < 600) begin
                @(negedge clk);
                n++;
            end
            if (e == 1) t0 = n;
        end
        p = 8'(n - t0);
    endtask : measure

    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        $display("wrong value at %0t: watchdog", $time);
        print_verdict();
    end

    initial begin
        logic [7:0] q;
        logic [23:0] g;
        logic [31:0] r;
        logic [3:0] al [3];
        int ex;
        bus_b.ce = 1'b0;
        bus_b.sclk = 1'b0;
        bus_b.sdi = 1'b0;
        model_reset();
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rd_chk(3'h1, 4'hE, "flag rst");
        rd_chk(3'h1, 4'h3, "week rst");
        wr_reg(3'h1, 4'hE, 8'h00);
        rd_chk(3'h1, 4'hE, "flag clr");
        wr_reg(3'h1, 4'h1, 8'h12);
        vdd_low = 1'b1;
        repeat (4) @(negedge clk);
        vdd_low = 1'b0;
        repeat (8) @(negedge clk);
        model_reset();
        rd_chk(3'h1, 4'h1, "min drop");
        rd_chk(3'h1, 4'hE, "flag drop");
        for (int b = 4; b < 8; b++) begin
            for (int k = 0; k < 3; k++) begin
                r = xs();
                al[k] = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : r[3:0];
                wr_reg(3'(b), al[k], r[15:8]);
            end
            for (int k = 0; k < 3; k++) begin
                rd_chk(3'(b), al[k], "ram");
            end
        end
        wr_reg(3'h1, 4'h1, 8'h59);
        rd_chk(3'h1, 4'h1, "min bcd");
        wr_reg(3'h2, 4'hC, 8'h45);
        rd_chk(3'h2, 4'hC, "sec alarm");
        wr_reg(3'h3, 4'h4, 8'h01);
        rd_chk(3'h3, 4'h4, "stamp mode");
        r = xs();
        wr_reg(3'h2, 4'h3, r[7:0]);
        rd_chk(3'h2, 4'h3, "stamp ram");
        wr_reg(3'h1, 4'hA, 8'h02);
        wr_reg(3'h1, 4'hB, 8'h00);
        wr_reg(3'h1, 4'hC, 8'h00);
        wr_reg(3'h1, 4'hF, 8'h10);
        wr_reg(3'h1, 4'hD, 8'h10);
        ex = 0;
        while (int_n !== 1'b0 && ex < 300) begin
            @(negedge clk);
            ex++;
        end
        check({7'h00, int_n}, 8'h00, "timer int");
        xfer(1'b0, 3'h1, 4'hE, 8'h00, q);
        check(q & 8'h1A, 8'h10 | model[1][14][7:0], "timer flag");
        // Stop the timer first, or the flag sets again
        wr_reg(3'h1, 4'hD, 8'h00);
        wr_reg(3'h1, 4'hE, 8'h00);
        repeat (4) @(negedge clk);
        check({7'h00, int_n}, 8'h01, "int release");
        for (int f = 0; f < 2; f++) begin
            wr_reg(3'h1, 4'hD, (f == 0) ? 8'h00 : 8'h40);
            measure(q);
            ex = (f == 0) ? HZ / 32768 : HZ / 1024;
            check(q, ex[7:0], "clock out");
        end
        raw(24'h41A500, 12, g);
        raw(24'hC10000, 24, g);
        check(g[7:0], 8'h00, "cut write");
        raw(24'h41A500, 16, g);
        raw(24'hC10000, 24, g);
        check(g[7:0], 8'hA5, "full write");
        wr_reg(3'h1, 4'h6, 8'h24);
        wr_reg(3'h1, 4'h5, 8'h02);
        wr_reg(3'h1, 4'h4, 8'h28);
        wr_reg(3'h1, 4'h2, 8'h23);
        wr_reg(3'h1, 4'h1, 8'h59);
        wr_reg(3'h1, 4'h0, 8'h60);
        repeat (HZ + 500) @(negedge clk);
        model[1][4] = 'h29;
        model[1][2] = 0;
        model[1][1] = 0;
        rd_chk(3'h1, 4'h4, "leap day");
        rd_chk(3'h1, 4'h5, "leap month");
        rd_chk(3'h1, 4'h2, "hour roll");
        rd_chk(3'h1, 4'h1, "min roll");
        // Capture back on, then one trigger edge
        wr_reg(3'h3, 4'h4, 8'h00);
        ts_trig = 1'b1;
        repeat (4) @(negedge clk);
        ts_trig = 1'b0;
        repeat (4) @(negedge clk);
        model[2][8] = 'h24;
        model[2][7] = 'h02;
        rd_chk(3'h2, 4'h8, "stamp year");
        rd_chk(3'h2, 4'h7, "stamp month");
        print_verdict();
    end
endmodule : test_rtc_function_set_bank_select
